/* File: src/rxp_port.sv */
// Expansion port: request/grant bus, collision flag, carrier-sense stream.
// Assumes peer pins arrive asynchronously; the tri-state wire is resolved outside.
`timescale 1ns/1ps
module rxp_port #(
   parameter int unsigned PRE_LEN = rxp_pkg::PRE_BITS   // Preamble bits to regenerate
) (
   input  wire logic       clk_i,            // Crystal-derived core clock
   input  wire logic       rst_i,            // Synchronous reset, active high
   // Repeater core side
   input  wire logic [8:0] port_rx_i,        // Per-port receive activity
   input  wire logic [8:0] port_col_i,       // Per-port collision
   input  wire logic       fifo_busy_i,      // Internal FIFO still draining
   input  wire logic       bit_valid_i,      // Repeated data bit offered
   output logic            bit_ready_o,      // Buffer can take the bit
   input  wire logic       bit_data_i,       // Repeated data bit
   input  wire logic       multiport_i,      // Collision involves several ports
   input  wire logic [8:0] carrier_i,        // Internal carrier senses
   output logic            peer_data_o,      // Sampled peer data
   output logic            peer_flag_o,      // Sampled peer collision flag
   output logic            peer_valid_o,     // Peer sampling active
   output logic            jam_start_o,      // Start own jam sequence
   // Expansion pins
   output logic            request_n_o,      // Bus request, active low
   input  wire logic       grant_n_i,        // Arbiter grant, active low
   input  wire logic       multi_col_n_i,    // Arbiter multi-device collision
   input  wire logic       expansion_data_line_i,
   output logic            expansion_data_line_o,
   output logic            expansion_data_line_oe_o,
   input  wire logic       jam_flag_i,
   output logic            jam_flag_o,
   output logic            jam_flag_oe_o,
   output logic            carrier_sense_serial_out_o,
   output logic            store_o            // High two cycles after each frame
);

   // ----------------------------------------
   // Input synchronisers, three stages each
   // ----------------------------------------
   logic [2:0] gnt_s_q, col_s_q, lin_s_q, flg_s_q;
   logic       gnt_q, col_q, lin_q, flg_q;   // Filtered levels

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gnt_s_q <= 3'h7;
         col_s_q <= 3'h7;
         lin_s_q <= 3'h0;
         flg_s_q <= 3'h0;
         gnt_q   <= 1'b1;
         col_q   <= 1'b1;
         lin_q   <= 1'b0;
         flg_q   <= 1'b0;
      end else begin
         gnt_s_q <= {gnt_s_q[1:0], grant_n_i};
         col_s_q <= {col_s_q[1:0], multi_col_n_i};
         lin_s_q <= {lin_s_q[1:0], expansion_data_line_i};
         flg_s_q <= {flg_s_q[1:0], jam_flag_i};
         // A change counts once stages two and three agree
         if (gnt_s_q[1] == gnt_s_q[2]) gnt_q <= gnt_s_q[2];
         if (col_s_q[1] == col_s_q[2]) col_q <= col_s_q[2];
         if (lin_s_q[1] == lin_s_q[2]) lin_q <= lin_s_q[2];
         if (flg_s_q[1] == flg_s_q[2]) flg_q <= flg_s_q[2];
      end
   end

   // ----------------------------------------
   // Request and direction
   // ----------------------------------------
   logic req_q, req_d;          // Active, registered (high = requesting)
   logic colliding;
   logic own;                   // Granted while requesting
   logic listen;                // Granted while idle

   always_comb begin
      colliding = |port_col_i;
      req_d     = (|port_rx_i) || colliding || fifo_busy_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_q <= 1'b0;
      end else begin
         req_q <= req_d;
      end
   end

   assign request_n_o = ~req_q;
   assign own         = req_q && !gnt_q;
   assign listen      = !req_q && !gnt_q;

   // Both pins float without grant, drive only when owned
   assign expansion_data_line_oe_o = own;
   assign jam_flag_oe_o            = own;

   // ----------------------------------------
   // Peer sampling
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         peer_data_o  <= 1'b0;
         peer_flag_o  <= 1'b0;
         peer_valid_o <= 1'b0;
         jam_start_o  <= 1'b0;
      end else begin
         peer_valid_o <= listen;
         if (listen) begin
            peer_data_o <= lin_q;
            peer_flag_o <= flg_q;
         end
         // Multi-device collision starts our own jam; core runs it
         jam_start_o <= !col_q || (listen && flg_q);
      end
   end

   // ----------------------------------------
   // Data buffer: a stalled line loses no bit
   // ----------------------------------------
   logic buf_valid, buf_data, buf_pop;

   rxp_buf2 #(.WIDTH(1)) u_buf (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (bit_valid_i),
      .in_ready_o  (bit_ready_o),
      .in_data_i   (bit_data_i),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_pop),
      .out_data_o  (buf_data)
   );

   // ----------------------------------------
   // Transmit sequencer: preamble, delimiter, data
   // ----------------------------------------
   rxp_pkg::rxp_tx_e st_q, st_d;
   logic [7:0]       bcnt_q, bcnt_d;       // Bits sent in this phase
   logic [7:0]       tick_q, tick_d;       // Cycles within a bit
   logic             tx_q, tx_d;           // NRZ bit on the line
   logic             bit_end;

   always_comb begin
      st_d    = st_q;
      bcnt_d  = bcnt_q;
      tick_d  = tick_q;
      tx_d    = tx_q;
      buf_pop = 1'b0;
      bit_end = (tick_q == 8'(rxp_pkg::BIT_CYC - 1));
      tick_d  = bit_end ? 8'h00 : tick_q + 8'h01;
      if (own && colliding) begin
         tx_d = !multiport_i;
      end
      case (st_q)
         rxp_pkg::RXP_IDLE: begin
            tick_d = 8'h00;
            bcnt_d = 8'h00;
            if (own && !colliding) begin
               st_d = rxp_pkg::RXP_PRE;
               tx_d = 1'b1;
            end
         end
         rxp_pkg::RXP_PRE: begin
            if (bit_end && !colliding) begin
               tx_d   = ~tx_q;              // Alternating preamble
               bcnt_d = bcnt_q + 8'h01;
               if (bcnt_q == 8'(PRE_LEN - 1)) begin
                  st_d   = rxp_pkg::RXP_SFD;
                  bcnt_d = 8'h00;
                  tx_d   = rxp_pkg::SFD_BYTE[0];
               end
            end
         end
         rxp_pkg::RXP_SFD: begin
            if (bit_end && !colliding) begin
               bcnt_d = bcnt_q + 8'h01;
               if (bcnt_q == 8'h07) begin
                  st_d = rxp_pkg::RXP_DATA;
                  // First data bit follows the delimiter at once, no repeat
                  if (buf_valid) begin
                     tx_d    = buf_data;
                     buf_pop = 1'b1;
                  end
               end else begin
                  tx_d = rxp_pkg::SFD_BYTE[bcnt_q[2:0] + 3'd1];
               end
            end
         end
         rxp_pkg::RXP_DATA: begin
            if (bit_end && !colliding && buf_valid) begin
               tx_d    = buf_data;
               buf_pop = 1'b1;
            end
         end
         default: st_d = rxp_pkg::RXP_IDLE;
      endcase
      if (!own) begin
         st_d = rxp_pkg::RXP_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q   <= rxp_pkg::RXP_IDLE;
         bcnt_q <= 8'h00;
         tick_q <= 8'h00;
         tx_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         bcnt_q <= bcnt_d;
         tick_q <= tick_d;
         tx_q   <= tx_d;
      end
   end

   assign expansion_data_line_o = tx_q;
   assign jam_flag_o            = own && colliding;    // Flag high marks collision

   // ----------------------------------------
   // Carrier-sense serialiser
   // ----------------------------------------
   logic [8:0] cs_lat_q, cs_lat_d;   // Latched senses since last frame
   logic [8:0] cs_sh_q, cs_sh_d;     // Shift register
   logic [3:0] cs_idx_q, cs_idx_d;   // Bit index, 0..10 incl. store gap
   logic       cs_out_q, cs_out_d;
   logic       str_q, str_d;

   always_comb begin
      cs_lat_d = cs_lat_q | carrier_i;   // Remember short activity between frames
      cs_sh_d  = cs_sh_q;
      cs_idx_d = cs_idx_q + 4'd1;
      cs_out_d = cs_out_q;
      str_d    = 1'b0;
      if (cs_idx_q < 4'(rxp_pkg::CS_PORTS)) begin
         cs_out_d = cs_sh_q[0];
         cs_sh_d  = {1'b0, cs_sh_q[8:1]};
      end else begin
         str_d = 1'b1;                                     // Store gap
      end
      if (cs_idx_q == 4'(rxp_pkg::CS_PORTS + rxp_pkg::CS_STROBE_CYC - 1)) begin
         cs_idx_d = 4'd0;
         cs_sh_d  = cs_lat_q | carrier_i;
         cs_lat_d = rxp_pkg::CS_RESET_VAL;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_lat_q <= rxp_pkg::CS_RESET_VAL;
         cs_sh_q  <= rxp_pkg::CS_RESET_VAL;
         cs_idx_q <= 4'd0;
         cs_out_q <= 1'b0;
         str_q    <= 1'b0;
      end else begin
         cs_lat_q <= cs_lat_d;
         cs_sh_q  <= cs_sh_d;
         cs_idx_q <= cs_idx_d;
         cs_out_q <= cs_out_d;
         str_q    <= str_d;
      end
   end

   assign carrier_sense_serial_out_o = cs_out_q;
   assign store_o                    = str_q;

endmodule

/* File: inc/rxp_pkg.sv */
// Constants and types for the repeater expansion port.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
//
// Contract
// - Grant while requesting: take data and flag.
// - Grant without request: lines carry peer's data.
// - Multi-device collision input triggers own jam.
// - Shift out nine carrier-sense states continuously.
// - Carrier-sense stream synchronous to device clock.
// - Active device drives NRZ data, preamble first.
// - Flag high: data 0 multiport, 1 single-port.
// - Data line not driven without grant.
// - Drive data only with request and grant.
// - Sample data with grant and no request.
// - Request low while receiving, colliding or draining.
// - Flag line obeys same direction rules as data.
package rxp_pkg;

   // ----------------------------------------
   // Carrier-sense stream
   // ----------------------------------------
   localparam int unsigned CS_PORTS       = 9;       // Attachment port plus eight TP ports
   localparam int unsigned CS_STROBE_CYC  = 2;       // Store pulse length after a frame
   localparam logic [8:0]  CS_RESET_VAL   = 9'h000;  // Latched senses after reset

   // ----------------------------------------
   // Preamble regeneration
   // ----------------------------------------
   localparam int unsigned PRE_BITS       = 56;      // Alternating bits before delimiter
   localparam logic [7:0]  SFD_BYTE       = 8'hD5;   // Delimiter, sent LSB first

   // ----------------------------------------
   // Bit timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ        = 200;     // Core clock rate
   localparam int unsigned BIT_NS         = 100;     // One bit at 10 Mb/s
   localparam int unsigned BIT_CYC        = (BIT_NS * CLK_MHZ) / 1000;

   // ----------------------------------------
   // Transmit sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      RXP_IDLE,
      RXP_PRE,
      RXP_SFD,
      RXP_DATA
   } rxp_tx_e;

endpackage

/* File: src/rxp_buf2.sv */
// Two-entry valid/ready buffer for the repeated bit stream.
// Assumes both sides on clk_i; upstream honours ready.
`timescale 1ns/1ps
module rxp_buf2 #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [WIDTH-1:0] mem_q [2];      // Two slots
   logic [WIDTH-1:0] mem_d [2];
   logic             rd_q, rd_d;     // Read pointer
   logic             wr_q, wr_d;     // Write pointer
   logic [1:0]       cnt_q, cnt_d;   // Occupancy

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic push;
      logic pop;
      push     = 1'b0;
      pop      = 1'b0;
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      rd_d     = rd_q;
      wr_d     = wr_q;
      cnt_d    = cnt_q;
      push     = in_valid_i && (cnt_q != 2'd2);
      pop      = out_ready_i && (cnt_q != 2'd0);
      if (push) begin
         mem_d[wr_q] = in_data_i;
         wr_d        = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      // Push and pop together leave the count alone
      if (push && !pop) begin
         cnt_d = cnt_q + 2'd1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'd1;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         rd_q     <= 1'b0;
         wr_q     <= 1'b0;
         cnt_q    <= 2'd0;
      end else begin
         mem_q[0] <= mem_d[0];
         mem_q[1] <= mem_d[1];
         rd_q     <= rd_d;
         wr_q     <= wr_d;
         cnt_q    <= cnt_d;
      end
   end

   assign in_ready_o  = (cnt_q != 2'd2);   // Honest full
   assign out_valid_o = (cnt_q != 2'd0);   // Honest empty
   assign out_data_o  = mem_q[rd_q];

endmodule

/* File: test/rxp_port_properties.sv */
// Pin-level checks for the expansion port.
// Assumes it is bound to rxp_port; one clock, sync reset.
`timescale 1ns/1ps
module rxp_port_properties (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [8:0] port_rx_i,
   input wire logic [8:0] port_col_i,
   input wire logic       fifo_busy_i,
   input wire logic       multiport_i,
   input wire logic       grant_n_i,
   input wire logic       multi_col_n_i,
   input wire logic       request_n_o,
   input wire logic       expansion_data_line_o,
   input wire logic       expansion_data_line_oe_o,
   input wire logic       jam_flag_o,
   input wire logic       jam_flag_oe_o,
   input wire logic       store_o,
   input wire logic       peer_valid_o,
   input wire logic       jam_start_o
);
   // ------------------------------------------
   // Checks; sync depth assumed under 8 cycles
   // ------------------------------------------
   logic act;  // Any reason to hold the bus
   assign act = (|port_rx_i) || (|port_col_i) || fifo_busy_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_req_on_act: assert property (act |=> !request_n_o)
      else $error("request missing on activity");
   chk_req_release: assert property (!act |=> request_n_o)
      else $error("request held while idle");
   chk_oe_needs_req: assert property (request_n_o |-> !expansion_data_line_oe_o)
      else $error("data driven without request");
   chk_flag_dir: assert property (jam_flag_oe_o == expansion_data_line_oe_o)
      else $error("flag direction differs from data");
   chk_no_grant_float: assert property (grant_n_i [*8] |-> !expansion_data_line_oe_o)
      else $error("data driven without grant");
   chk_take_bus: assert property ((!grant_n_i && !request_n_o) [*8] |-> jam_flag_oe_o)
      else $error("bus not taken on grant");
   chk_col_kind: assert property ($past(expansion_data_line_oe_o && (|port_col_i))
      && expansion_data_line_oe_o |-> expansion_data_line_o == !$past(multiport_i))
      else $error("collision kind wrong on data");
   chk_col_flag: assert property (expansion_data_line_oe_o && (|port_col_i) |-> jam_flag_o)
      else $error("flag low in collision");
   chk_store_len: assert property ($rose(store_o) |=> store_o ##1 !store_o)
      else $error("store pulse not two cycles");
   chk_store_period: assert property ($rose(store_o) |-> ##11 $rose(store_o))
      else $error("carrier frame not eleven cycles");
   chk_listen_valid: assert property ((!grant_n_i && request_n_o) [*8] |-> peer_valid_o)
      else $error("not listening with grant only");
   chk_multi_jam: assert property (!multi_col_n_i [*8] |-> jam_start_o)
      else $error("no jam on multi-device collision");
endmodule
bind rxp_port rxp_port_properties u_rxp_port_properties (.*);

/* File: test/rxp_peer_model.sv */
// Arbiter plus one peer repeater on the shared lines.
// Assumes the bench says when the peer is active.
`timescale 1ns/1ps
module rxp_peer_model (
   input  wire logic dev_req_n_i,  // Device request
   input  wire logic peer_act_i,   // Peer has traffic
   input  wire logic peer_bit_i,   // Peer data bit
   input  wire logic peer_flag_i,  // Peer collision flag
   input  wire logic dut_oe_i,     // Device drives data
   input  wire logic dut_bit_i,
   input  wire logic dut_foe_i,    // Device drives flag
   input  wire logic dut_flag_i,
   output logic      grant_n_o,
   output logic      multi_col_n_o,
   output logic      line_o,       // Resolved data wire
   output logic      flag_o        // Resolved flag wire
);
   logic peer_owns;  // Peer talks only when device is quiet
   // Grant goes to everyone while anyone is active
   assign grant_n_o = !(!dev_req_n_i || peer_act_i);
   // Two active devices is a multi-device collision
   assign multi_col_n_o = !(!dev_req_n_i && peer_act_i);
   assign peer_owns = peer_act_i && dev_req_n_i;
   // Pull-up on data, pull-down on flag when nobody drives
   assign line_o = dut_oe_i ? dut_bit_i : (peer_owns ? peer_bit_i : 1'b1);
   assign flag_o = dut_foe_i ? dut_flag_i : (peer_owns ? peer_flag_i : 1'b0);
endmodule

/* File: test/repeater_expansion_port_tb.sv */
// Self-checking bench for the expansion port.
// Assumes rxp_port, its checker and the peer model.
`timescale 1ns/1ps
module repeater_expansion_port_tb;
   localparam int PRE = 8;   // Short preamble for run time
   localparam int NB  = 12;  // Data bits pushed
   logic clk_i = 0, rst_i = 1, fifo_busy_i = 0, bit_valid_i = 0, bit_data_i = 0;
   logic multiport_i = 0, peer_act = 0, peer_bit = 0, peer_flag = 0, push_en = 0, took = 0;
   logic [8:0] port_rx_i = 0, port_col_i = 0, carrier_i = 0, hist = 0;
   logic bit_ready_o, peer_data_o, peer_flag_o, peer_valid_o, jam_start_o;
   logic request_n_o, grant_n, mcol_n, line, flag, d_o, d_oe, f_o, f_oe, cs_o, store_o;
   int bad_count = 0, num_checks = 0, seed = 32'hcf72378e, npush = 0, n, k;
   int eq[$];  // Expected bits on the wire
   always #2.5 clk_i = !clk_i;
   rxp_port #(.PRE_LEN(PRE)) u_rxp_port (.clk_i(clk_i), .rst_i(rst_i),
      .port_rx_i(port_rx_i), .port_col_i(port_col_i), .fifo_busy_i(fifo_busy_i),
      .bit_valid_i(bit_valid_i), .bit_ready_o(bit_ready_o), .bit_data_i(bit_data_i),
      .multiport_i(multiport_i), .carrier_i(carrier_i), .peer_data_o(peer_data_o),
      .peer_flag_o(peer_flag_o), .peer_valid_o(peer_valid_o), .jam_start_o(jam_start_o),
      .request_n_o(request_n_o), .grant_n_i(grant_n), .multi_col_n_i(mcol_n),
      .expansion_data_line_i(line), .expansion_data_line_o(d_o),
      .expansion_data_line_oe_o(d_oe), .jam_flag_i(flag), .jam_flag_o(f_o),
      .jam_flag_oe_o(f_oe), .carrier_sense_serial_out_o(cs_o), .store_o(store_o));
   rxp_peer_model u_rxp_peer_model (.dev_req_n_i(request_n_o), .peer_act_i(peer_act),
      .peer_bit_i(peer_bit), .peer_flag_i(peer_flag), .dut_oe_i(d_oe), .dut_bit_i(d_o),
      .dut_foe_i(f_oe), .dut_flag_i(f_o), .grant_n_o(grant_n), .multi_col_n_o(mcol_n),
      .line_o(line), .flag_o(flag));
   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   task step(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask
   task chk(input logic [8:0] got, input logic [8:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task report_and_stop;
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Serial carrier bits, shifted outside store cycles; port 0 ends at bit 0
   always @(negedge clk_i) if (!store_o) hist <= {cs_o, hist[8:1]};
   // Pusher: random bits, held until taken; accepted bits join the model
   always @(posedge clk_i) if (push_en) begin
      took = bit_valid_i && bit_ready_o;
      if (took) begin
         eq.push_back(bit_data_i);
         npush++;
      end
      #1;
      if (!bit_valid_i || took) bit_data_i = $random(seed);
      bit_valid_i = (npush < NB);
   end
   initial begin
      #50000;
      bad_count++;
      report_and_stop;
   end
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      step(6);
      rst_i = 0;
      for (k = 0; k < 3; k++) begin  // Carrier stream, random patterns
         carrier_i = $random(seed);
         step(30);
         for (n = 0; n < 12 && store_o !== 1; n++) step(1);
         chk(hist, carrier_i, "carrier stream");
      end
      for (n = 0; n < PRE; n++) eq.push_back(n % 2 == 0);
      for (n = 0; n < 8; n++) eq.push_back(n == 0 || n == 2 || n == 4 || n == 6 || n == 7);
      port_rx_i = 9'h004;
      push_en = 1;
      for (n = 0; n < 50 && d_oe !== 1; n++) step(1);
      chk(d_oe, 1, "bus not taken");
      step(3);
      chk(bit_ready_o, 0, "buffer takes a third bit");
      step(8);
      while (eq.size() > 0) begin  // Mid-bit samples of the wire
         chk(d_o, eq.pop_front(), "repeated bit");
         step(20);
      end
      port_col_i = 9'h008;
      for (k = 0; k < 2; k++) begin  // Both collision kinds
         multiport_i = k;
         step(3);
         chk(f_o, 1, "flag in collision");
         chk(d_o, !k, "collision kind");
      end
      port_col_i = 0;
      port_rx_i = 0;
      fifo_busy_i = 1;
      step(3);
      chk(request_n_o, 0, "request while draining");
      fifo_busy_i = 0;
      step(3);
      chk(request_n_o, 1, "request after drain");
      peer_act = 1;
      for (k = 0; k < 4; k++) begin  // Listen to the peer
         peer_bit = $random(seed);
         peer_flag = $random(seed);
         step(20);
         chk(peer_valid_o, 1, "not listening");
         chk(peer_data_o, peer_bit, "peer data");
         chk(peer_flag_o, peer_flag, "peer flag");
      end
      port_rx_i = 9'h001;
      step(12);
      chk(jam_start_o, 1, "no jam on multi collision");
      port_rx_i = 0;
      peer_act = 0;
      step(12);
      chk(d_oe, 0, "drive without grant");
      report_and_stop;
   end
endmodule
